// ---- rtl/dlc_defines.svh ----
// constants of the line control and mode block: indexes, bit positions, timing
`ifndef DLC_DEFINES_SVH
`define DLC_DEFINES_SVH
// ----------------------------------------------------------------------
// register indexes (byte address on the bus is four times the index)
// ----------------------------------------------------------------------
`define DLC_IDX_TEST 7'h31
`define DLC_IDX_LOOP 7'h32
`define DLC_IDX_HOOK 7'h35
`define DLC_IDX_POWER 7'h36
`define DLC_IDX_RATE 7'h37
`define DLC_IDX_TXLVL 7'h38
`define DLC_IDX_RXLVL 7'h39
`define DLC_IDX_HREV 7'h3b
`define DLC_IDX_LINKST 7'h3c
`define DLC_IDX_LINE_SIDE_REVISION 7'h3d
`define DLC_IDX_LEGTERM 7'h3e
`define DLC_IDX_GAIN 7'h3f
`define DLC_IDX_FILTER 7'h40
`define DLC_IDX_CAL 7'h41
`define DLC_IDX_OVLST 7'h43
`define DLC_IDX_TERM 7'h4a
// ----------------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------------
`define DLC_B_BARRIER_LB 1
`define DLC_B_MAP_SEL 6
`define DLC_B_ANALOG_LB 3
`define DLC_B_HYBRID_EN 1
`define DLC_B_OFF_HOOK 0
`define DLC_B_LINE_PD 4
`define DLC_B_SLEEP_PD 3
`define DLC_B_FRAME_DET 6
`define DLC_B_RX_MUTE 3
`define DLC_B_TX_MUTE 7
`define DLC_B_FILTER_IIR 4
`define DLC_B_OVL_EN 3
`define DLC_B_CAL_DIS 5
`define DLC_B_MANUAL_CAL_TRIGGER 6
`define DLC_B_OVL_FLAG 0
`define DLC_B_CURRENT_LIMIT_SELECT 1
`define DLC_B_OVERRIDE 6
// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define DLC_RST_LOOP 8'h02
`define DLC_RST_POWER 8'h10
`define DLC_OVL_THR_HI_MA 8'ha0
`define DLC_OVL_THR_LO_MA 8'h3c
`define DLC_STEP_DB 4'h3
`define DLC_MAX_STEP 3'h4
`define DLC_RATE_CODES 4'ha
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define DLC_CLK_HZ 10000000
`define DLC_CAL_TIME_MS 256
`endif

// ---- rtl/dlc_line_ctrl.sv ----
// control and mode logic of the host-side line access device
//
// Behaviour
// - sensed overload gives 800 ohm and flag
// - overload threshold 160 mA, or 60 mA limited
// - gain and attenuation 0..12 dB, mute bits
// - four-bit field selects one of ten rates
// - filter bit picks IIR or default FIR
// - two powerdown bits select four power modes
// - after reset: line powerdown, link inactive
// - normal mode needs both bits clear, rate valid
// - sleep and full powerdown leave only by reset
// - auto calibration on off-hook or power loss
// - manual calibration: disable auto, pulse trigger
// - line powerdown loops transmit data to received data
// - link up switches data, raises frame detect
// - barrier, analog and internal loopback controls
// - read-only host and line revision fields
// - map select defaults legacy, rewritable at any time
// - alternate map gives wide levels, split termination
// - legacy termination codes map to split fields
// - alternate-map termination override forces 800 ohm mode
`timescale 1ns/1ns
`include "dlc_defines.svh"
module dlc_line_ctrl
   import dlc_pkg::*;
#(
   parameter logic [3:0] HOST_REV = 4'h1, // arbitrary value
   parameter int CAL_CYCLES = `DLC_CAL_TIME_MS * (`DLC_CLK_HZ / 1000),
   parameter int SAMPLE_W = 16
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [8:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] line_current_ma_i,
   input wire logic line_power_ok_i,
   input wire logic dc_stable_i,
   input wire logic link_frame_i,
   input wire logic [3:0] line_side_revision_i,
   input wire logic [SAMPLE_W-1:0] tx_data_i,
   input wire logic [SAMPLE_W-1:0] rx_line_i,
   output logic [SAMPLE_W-1:0] rx_data_o,
   output logic [SAMPLE_W-1:0] tx_line_o,
   output logic link_active_o,
   output logic off_hook_o,
   output logic term_800_o,
   output dlc_term_t term_o,
   output logic [3:0] rx_gain_db_o,
   output logic [3:0] tx_atten_db_o,
   output logic [7:0] tx_level_o,
   output logic [7:0] rx_level_o,
   output logic [13:0] sample_rate_hz_o,
   output logic filter_iir_o,
   output dlc_pmode_t power_mode_o,
   output logic cal_busy_o,
   output logic barrier_loopback_o,
   output logic line_analog_loopback_o,
   output logic hybrid_enable_o
);
   localparam int CNT_W = $clog2(CAL_CYCLES + 1);
   localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES - 1);

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------
   // step code to dB; codes above the top step saturate at 12 dB
   function automatic logic [3:0] step_db(input logic [2:0] code);
      logic [3:0] db;
      db = (code > `DLC_MAX_STEP) ? 4'hc : 4'(code * `DLC_STEP_DB);
      return db;
   endfunction

   // rate code to Hz; unlisted codes give zero and count as invalid
   function automatic logic [13:0] rate_hz(input logic [3:0] code);
      logic [13:0] hz;
      case (code)
         4'h0: hz = 14'd7200;
         4'h1: hz = 14'd8000;
         4'h2: hz = 14'd8229;
         4'h3: hz = 14'd8400;
         4'h4: hz = 14'd9000;
         4'h5: hz = 14'd9600;
         4'h6: hz = 14'd10286;
         4'h7: hz = 14'd12000;
         4'h8: hz = 14'd13714;
         4'h9: hz = 14'd16000;
         default: hz = 14'h0;
      endcase
      return hz;
   endfunction

   // ----------------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------------
   logic [7:0] test_ff, loop_ff, hook_ff, power_ff, rate_ff, txlvl_ff, rxlvl_ff;
   logic [7:0] legterm_ff, gain_ff, filter_ff, cal_ff, term_ff;
   logic overload_flag_ff, ovl_active_ff, ack_ff, frame_ff;
   logic [31:0] rdat_ff;
   logic hook_d_ff, pwr_d_ff, manual_cal_trigger_d_ff;
   dlc_pmode_t mode_ff, nxt_mode;
   dlc_cal_t cal_ff_st, nxt_cal;
   logic [CNT_W-1:0] cal_cnt_ff;

   // ----------------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------------
   // ack comes one cycle after the request and drops the cycle after
   wire [6:0] idx = wb_adr_i[8:2];
   wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
   wire wr = ce_i & req & wb_we_i & wb_sel_i[0];
   wire [7:0] wd = wb_dat_i[7:0];
   wire wr_test = wr & (idx == `DLC_IDX_TEST);
   wire wr_loop = wr & (idx == `DLC_IDX_LOOP);
   wire wr_hook = wr & (idx == `DLC_IDX_HOOK);
   wire wr_power = wr & (idx == `DLC_IDX_POWER);
   wire wr_rate = wr & (idx == `DLC_IDX_RATE);
   wire wr_txlvl = wr & (idx == `DLC_IDX_TXLVL);
   wire wr_rxlvl = wr & (idx == `DLC_IDX_RXLVL);
   wire wr_legterm = wr & (idx == `DLC_IDX_LEGTERM);
   wire wr_gain = wr & (idx == `DLC_IDX_GAIN);
   wire wr_filter = wr & (idx == `DLC_IDX_FILTER);
   wire wr_cal = wr & (idx == `DLC_IDX_CAL);
   wire wr_ovlst = wr & (idx == `DLC_IDX_OVLST);
   wire wr_term = wr & (idx == `DLC_IDX_TERM);

   // ----------------------------------------------------------------------
   // derived control
   // ----------------------------------------------------------------------
   wire map_sel = test_ff[`DLC_B_MAP_SEL];
   wire line_pd = power_ff[`DLC_B_LINE_PD];
   wire sleep_pd = power_ff[`DLC_B_SLEEP_PD];
   wire off_hook = hook_ff[`DLC_B_OFF_HOOK];
   wire rate_valid = rate_ff[3:0] < `DLC_RATE_CODES;
   wire cal_dis = cal_ff[`DLC_B_CAL_DIS];
   wire manual_cal_trigger = cal_ff[`DLC_B_MANUAL_CAL_TRIGGER];
   // mute bits only exist in the legacy map; wide level fields replace them
   wire rx_mute = ~map_sel & gain_ff[`DLC_B_RX_MUTE];
   wire tx_mute = ~map_sel & gain_ff[`DLC_B_TX_MUTE];

   // legacy termination code translated to split fields
   dlc_term_t legacy_term;
   always_comb begin
      case (legterm_ff[1:0])
         2'b00: legacy_term = '{2'b00, 2'b11, 1'b0};
         2'b01: legacy_term = '{2'b01, 2'b11, 1'b0};
         2'b10: legacy_term = '{2'b10, 2'b00, 1'b0};
         default: legacy_term = '{2'b10, 2'b00, 1'b1};
      endcase
   end
   wire dlc_term_t split_term = '{term_ff[5:4], term_ff[3:2], term_ff[`DLC_B_CURRENT_LIMIT_SELECT]};
   wire dlc_term_t eff_term = map_sel ? split_term : legacy_term;
   wire override_800 = map_sel & term_ff[`DLC_B_OVERRIDE];

   // overload sensing: limited termination lowers the trip point
   wire [7:0] ovl_thr = eff_term.current_limit_select ? `DLC_OVL_THR_LO_MA
                                                      : `DLC_OVL_THR_HI_MA;
   wire ovl_live = cal_ff[`DLC_B_OVL_EN] & off_hook & (mode_ff == DLC_PM_NORMAL)
                   & (line_current_ma_i > ovl_thr);
   wire ovl_clear = wr_ovlst & ~wd[`DLC_B_OVL_FLAG];

   // calibration triggers
   wire hook_rise = off_hook & ~hook_d_ff;
   wire power_lost = pwr_d_ff & ~line_power_ok_i;
   wire auto_start = ~cal_dis & (hook_rise | power_lost);
   wire manual_start = cal_dis & manual_cal_trigger_d_ff & ~manual_cal_trigger;

   // ----------------------------------------------------------------------
   // power mode next state
   // ----------------------------------------------------------------------
   // sleep and full powerdown ignore the bits until the reset pin pulses
   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         DLC_PM_NORMAL, DLC_PM_RESET: begin
            if (line_pd & sleep_pd) begin
               nxt_mode = DLC_PM_FULL;
            end else if (sleep_pd) begin
               nxt_mode = DLC_PM_SLEEP;
            end else if (line_pd) begin
               nxt_mode = DLC_PM_RESET;
            end else if (rate_valid) begin
               nxt_mode = DLC_PM_NORMAL;
            end else begin
               nxt_mode = DLC_PM_RESET;
            end
         end
         DLC_PM_SLEEP: nxt_mode = DLC_PM_SLEEP;
         DLC_PM_FULL: nxt_mode = DLC_PM_FULL;
         default: nxt_mode = DLC_PM_RESET;
      endcase
   end

   // ----------------------------------------------------------------------
   // calibration next state
   // ----------------------------------------------------------------------
   // auto runs wait for a settled dc termination, manual runs start at once
   always_comb begin
      nxt_cal = cal_ff_st;
      case (cal_ff_st)
         DLC_CAL_IDLE: begin
            if (manual_start) begin
               nxt_cal = DLC_CAL_RUN;
            end else if (auto_start) begin
               nxt_cal = DLC_CAL_WAIT;
            end
         end
         DLC_CAL_WAIT: begin
            if (dc_stable_i) begin
               nxt_cal = DLC_CAL_RUN;
            end
         end
         DLC_CAL_RUN: begin
            if (cal_cnt_ff == CAL_LAST) begin
               nxt_cal = DLC_CAL_IDLE;
            end
         end
         default: nxt_cal = DLC_CAL_IDLE;
      endcase
   end

   // ----------------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------------
   // line-side fields read zero while the link is down; unmapped reads zero
   logic [7:0] rd_byte;
   wire link_up = (mode_ff == DLC_PM_NORMAL);
   always_comb begin
      if (idx == `DLC_IDX_TEST) begin
         rd_byte = test_ff;
      end else if (idx == `DLC_IDX_LOOP) begin
         rd_byte = loop_ff;
      end else if (idx == `DLC_IDX_HOOK) begin
         rd_byte = hook_ff;
      end else if (idx == `DLC_IDX_POWER) begin
         rd_byte = power_ff;
      end else if (idx == `DLC_IDX_RATE) begin
         rd_byte = rate_ff;
      end else if (idx == `DLC_IDX_TXLVL) begin
         rd_byte = txlvl_ff;
      end else if (idx == `DLC_IDX_RXLVL) begin
         rd_byte = rxlvl_ff;
      end else if (idx == `DLC_IDX_HREV) begin
         rd_byte = {4'h0, HOST_REV};
      end else if (idx == `DLC_IDX_LINKST) begin
         rd_byte = {1'b0, frame_ff, 6'h0};
      end else if (idx == `DLC_IDX_LINE_SIDE_REVISION) begin
         rd_byte = link_up ? {2'b00, line_side_revision_i, 2'b00} : 8'h0;
      end else if (idx == `DLC_IDX_LEGTERM) begin
         rd_byte = legterm_ff;
      end else if (idx == `DLC_IDX_GAIN) begin
         rd_byte = gain_ff;
      end else if (idx == `DLC_IDX_FILTER) begin
         rd_byte = filter_ff;
      end else if (idx == `DLC_IDX_CAL) begin
         rd_byte = cal_ff;
      end else if (idx == `DLC_IDX_OVLST) begin
         rd_byte = {7'h0, overload_flag_ff};
      end else if (idx == `DLC_IDX_TERM) begin
         rd_byte = term_ff;
      end else begin
         rd_byte = 8'h0;
      end
   end

   // ----------------------------------------------------------------------
   // bus answer
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0;
      end else if (ce_i) begin
         ack_ff <= req;
         rdat_ff <= {24'h0, rd_byte};
      end
   end

   // ----------------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------------
   // reset leaves line powerdown set and the hybrid enabled
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         test_ff <= 8'h0;
         loop_ff <= `DLC_RST_LOOP;
         hook_ff <= 8'h0;
         power_ff <= `DLC_RST_POWER;
         rate_ff <= 8'h0;
         txlvl_ff <= 8'h0;
         rxlvl_ff <= 8'h0;
         legterm_ff <= 8'h0;
         gain_ff <= 8'h0;
         filter_ff <= 8'h0;
         cal_ff <= 8'h0;
         term_ff <= 8'h0;
      end else begin
         if (wr_test) test_ff <= wd;
         if (wr_loop) loop_ff <= wd;
         if (wr_hook) hook_ff <= wd;
         if (wr_power) power_ff <= wd;
         if (wr_rate) rate_ff <= wd;
         if (wr_txlvl) txlvl_ff <= wd;
         if (wr_rxlvl) rxlvl_ff <= wd;
         if (wr_legterm) legterm_ff <= wd;
         if (wr_gain) gain_ff <= wd;
         if (wr_filter) filter_ff <= wd;
         if (wr_cal) cal_ff <= wd;
         if (wr_term) term_ff <= wd;
      end
   end

   // ----------------------------------------------------------------------
   // state: power mode, overload, calibration
   // ----------------------------------------------------------------------
   // a new overload in the clearing cycle wins, so no event is lost
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         mode_ff <= DLC_PM_RESET;
         overload_flag_ff <= 1'b0;
         ovl_active_ff <= 1'b0;
         frame_ff <= 1'b0;
         cal_ff_st <= DLC_CAL_IDLE;
         cal_cnt_ff <= '0;
         hook_d_ff <= 1'b0;
         pwr_d_ff <= 1'b0;
         manual_cal_trigger_d_ff <= 1'b0;
      end else if (ce_i) begin
         mode_ff <= nxt_mode;
         ovl_active_ff <= ovl_live;
         overload_flag_ff <= ovl_live | (overload_flag_ff & ~ovl_clear);
         frame_ff <= link_up & link_frame_i;
         cal_ff_st <= nxt_cal;
         cal_cnt_ff <= (cal_ff_st == DLC_CAL_RUN) ? cal_cnt_ff + 1'b1 : '0;
         hook_d_ff <= off_hook;
         pwr_d_ff <= line_power_ok_i;
         manual_cal_trigger_d_ff <= manual_cal_trigger;
      end
   end

   // ----------------------------------------------------------------------
   // outputs, all registered
   // ----------------------------------------------------------------------
   // loopback output: the received path takes host transmit data while line
   // powerdown holds the link down; adds one clock of latency either way
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rx_data_o <= '0;
         tx_line_o <= '0;
         link_active_o <= 1'b0;
         off_hook_o <= 1'b0;
         term_800_o <= 1'b0;
         term_o <= '0;
         rx_gain_db_o <= 4'h0;
         tx_atten_db_o <= 4'h0;
         tx_level_o <= 8'h0;
         rx_level_o <= 8'h0;
         sample_rate_hz_o <= 14'h0;
         filter_iir_o <= 1'b0;
         power_mode_o <= DLC_PM_RESET;
         cal_busy_o <= 1'b0;
         barrier_loopback_o <= 1'b0;
         line_analog_loopback_o <= 1'b0;
         hybrid_enable_o <= 1'b1;
      end else if (ce_i) begin
         if (rx_mute) begin
            rx_data_o <= '0;
         end else begin
            rx_data_o <= line_pd ? tx_data_i : rx_line_i;
         end
         tx_line_o <= tx_mute ? '0 : tx_data_i;
         link_active_o <= (nxt_mode == DLC_PM_NORMAL);
         off_hook_o <= off_hook;
         term_800_o <= ovl_live | override_800;
         term_o <= eff_term;
         rx_gain_db_o <= step_db(gain_ff[2:0]);
         tx_atten_db_o <= step_db(gain_ff[6:4]);
         tx_level_o <= map_sel ? txlvl_ff : {6'h0, txlvl_ff[1:0]};
         rx_level_o <= map_sel ? rxlvl_ff : {6'h0, rxlvl_ff[1:0]};
         sample_rate_hz_o <= rate_hz(rate_ff[3:0]);
         filter_iir_o <= filter_ff[`DLC_B_FILTER_IIR];
         power_mode_o <= nxt_mode;
         cal_busy_o <= (nxt_cal == DLC_CAL_RUN);
         barrier_loopback_o <= test_ff[`DLC_B_BARRIER_LB];
         line_analog_loopback_o <= loop_ff[`DLC_B_ANALOG_LB];
         hybrid_enable_o <= loop_ff[`DLC_B_HYBRID_EN];
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   a_ack_single_pulse: assert property (ack_ff |=> !ack_ff)
      else $error("bus ack held longer than one cycle");
   a_overload_sets_flag: assert property (ce_i && ovl_live |=> overload_flag_ff && term_800_o)
      else $error("overload did not set flag and 800 ohm mode");
   a_flag_clear_set_wins: assert property (ce_i && ovl_live && ovl_clear |=> overload_flag_ff)
      else $error("overload lost in the clearing cycle");
   a_threshold_by_limit: assert property
      (ovl_thr == (eff_term.current_limit_select ? 8'h3c : 8'ha0))
      else $error("overload threshold does not follow current limit");
   a_reset_mode_entry: assert property ($rose(reset_n_i) |-> mode_ff == DLC_PM_RESET && line_pd)
      else $error("reset did not enter reset operation");
   a_sleep_stays_held: assert property
      (mode_ff inside {DLC_PM_SLEEP, DLC_PM_FULL} |=> $stable(mode_ff))
      else $error("sleep or powerdown left without reset");
   a_loopback_data_path: assert property
      (ce_i && line_pd && !rx_mute |=> rx_data_o == $past(tx_data_i))
      else $error("loopback data path wrong");
   a_frame_needs_link: assert property (ce_i && !link_up |=> !frame_ff ##1 !frame_ff or link_up)
      else $error("frame detect without link");
   a_legacy_tbr_code: assert property
      (!map_sel && legterm_ff[1:0] == 2'b11 |-> eff_term == '{2'b10, 2'b00, 1'b1})
      else $error("legacy termination code misread");
   a_cal_run_length: assert property
      (ce_i && cal_ff_st == DLC_CAL_RUN && cal_cnt_ff == CAL_LAST |=> cal_ff_st == DLC_CAL_IDLE)
      else $error("calibration did not end after its length");
   a_manual_cal_start: assert property
      (ce_i && cal_ff_st == DLC_CAL_IDLE && manual_start |=> cal_ff_st == DLC_CAL_RUN ##0 cal_cnt_ff == '0)
      else $error("manual calibration did not start");

   c_overload_seen: cover property (ce_i && ovl_live ##1 overload_flag_ff);
   c_enter_normal: cover property (mode_ff == DLC_PM_RESET ##1 mode_ff == DLC_PM_NORMAL);
   c_enter_sleep: cover property (mode_ff == DLC_PM_NORMAL ##1 mode_ff == DLC_PM_SLEEP);
   c_cal_finishes: cover property (cal_ff_st == DLC_CAL_RUN ##1 cal_ff_st == DLC_CAL_IDLE);
endmodule

// ---- rtl/dlc_pkg.sv ----
// types shared by the line control and mode block
package dlc_pkg;
   // ----------------------------------------------------------------------
   // power operation modes, one-hot
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      DLC_PM_NORMAL = 4'h1,
      DLC_PM_RESET = 4'h2,
      DLC_PM_SLEEP = 4'h4,
      DLC_PM_FULL = 4'h8
   } dlc_pmode_t;
   // ----------------------------------------------------------------------
   // calibration sequencer states, one-hot
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      DLC_CAL_IDLE = 3'h1,
      DLC_CAL_WAIT = 3'h2,
      DLC_CAL_RUN = 3'h4
   } dlc_cal_t;
   // dc termination settings handed to the line side
   typedef struct packed {
      logic [1:0] dc_voltage_select;
      logic [1:0] minimum_current_select;
      logic current_limit_select;
   } dlc_term_t;
endpackage

// ---- verif/dlc_line_side_model.sv ----
// behavioural model of the isolated line-side device
`timescale 1ns/1ns
module dlc_line_side_model #(
   parameter logic [3:0] LINE_REV = 4'h5 // arbitrary value
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic link_up_i,
   input wire logic hook_i,
   input wire logic [7:0] load_ma_i,
   output logic [7:0] current_o,
   output logic dc_stable_o,
   output logic frame_o,
   output logic [3:0] rev_o,
   output logic [15:0] rx_o
);
   logic [2:0] settle_ff;
   logic [15:0] cnt_ff;
   // termination needs a few cycles to settle after going off-hook
   always_ff @(posedge clk_i) begin
      if (!reset_n_i || !hook_i) settle_ff <= 3'h0;
      else if (settle_ff != 3'h4) settle_ff <= settle_ff + 3'h1;
      cnt_ff <= reset_n_i ? cnt_ff + 16'h1 : 16'h0;
   end
   assign dc_stable_o = (settle_ff == 3'h4);
   assign current_o = hook_i ? load_ma_i : 8'h00; // loop current only off-hook
   assign frame_o = link_up_i; // frames only while the link runs
   // a dead link shows nothing useful, so the values are scrambled
   assign rev_o = link_up_i ? LINE_REV : ~LINE_REV;
   assign rx_o = link_up_i ? cnt_ff : ~cnt_ff;
endmodule

// ---- verif/tb.sv ----
// self-checking bench of the line control block
`timescale 1ns/1ns
`include "dlc_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
   import dlc_pkg::*;
   logic clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, line_power_ok_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, dc_stable_i;
   logic link_frame_i, link_active_o, off_hook_o, term_800_o, filter_iir_o, cal_busy_o;
   logic barrier_loopback_o, line_analog_loopback_o, hybrid_enable_o;
   logic [8:0] wb_adr_i = 9'h0;
   logic [3:0] wb_sel_i = 4'hf, line_side_revision_i, rx_gain_db_o, tx_atten_db_o;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [7:0] line_current_ma_i, load_ma = 8'h0, tx_level_o, rx_level_o, q;
   logic [15:0] tx_data_i = 16'h0, rx_line_i, rx_data_o, tx_line_o, s;
   logic [13:0] sample_rate_hz_o;
   dlc_term_t term_o;
   dlc_pmode_t power_mode_o;
   int errors = 0, checked = 0;
   int hz[10] = '{7200, 8000, 8229, 8400, 9000, 9600, 10286, 12000, 13714, 16000};
   dlc_line_ctrl #(.CAL_CYCLES(20), .HOST_REV(4'h9)) dut (.*); // revision value arbitrary
   dlc_line_side_model far (.clk_i(clk_i), .reset_n_i(reset_n_i), .link_up_i(link_active_o),
      .hook_i(off_hook_o), .load_ma_i(load_ma), .current_o(line_current_ma_i),
      .dc_stable_o(dc_stable_i), .frame_o(link_frame_i), .rev_o(line_side_revision_i),
      .rx_o(rx_line_i));
   initial forever #50 clk_i = ~clk_i;
   task automatic close_out;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one classic cycle; read data lands in q, ack wait is bounded
   task automatic bus(input logic w, input logic [6:0] a, input logic [7:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {a, 2'b00};
      wb_dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         errors++;
         close_out();
      end
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic t_reset;
      `CHK(power_mode_o, DLC_PM_RESET)
      `CHK({hybrid_enable_o, filter_iir_o}, 2'h2)
      bus(1'b0, `DLC_IDX_POWER, 8'h0);
      `CHK(q, `DLC_RST_POWER)
      bus(1'b0, `DLC_IDX_TEST, 8'h0);
      `CHK(q, 8'h00)
      bus(1'b1, `DLC_IDX_HREV, 8'hff);
      bus(1'b0, `DLC_IDX_HREV, 8'h0);
      `CHK(q, 8'h09)
      bus(1'b0, `DLC_IDX_LINE_SIDE_REVISION, 8'h0);
      `CHK(q, 8'h00)
   endtask
   // loopback, gain steps, mute, rate table and filter while still in reset operation
   task automatic t_paths;
      tx_data_i <= 16'h1234;
      bus(1'b1, `DLC_IDX_TXLVL, 8'ha5);
      `CHK({rx_data_o, tx_level_o}, 24'h123401)
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, `DLC_IDX_GAIN, {1'b0, 3'(i), 1'b0, 3'(i)});
         `CHK({rx_gain_db_o, tx_atten_db_o}, {4'(3 * i), 4'(3 * i)})
      end
      bus(1'b1, `DLC_IDX_GAIN, 8'h88);
      `CHK({rx_data_o, tx_line_o}, 32'h0)
      for (int i = 0; i < 16; i++) begin
         bus(1'b1, `DLC_IDX_RATE, 8'(i));
         `CHK(sample_rate_hz_o, (i < 10) ? 14'(hz[i]) : 14'h0)
      end
      bus(1'b1, `DLC_IDX_FILTER, 8'h10);
      `CHK(filter_iir_o, 1'b1)
   endtask
   // link up, off-hook, calibration, then overload under legacy termination codes
   task automatic t_line;
      int n;
      n = 0;
      bus(1'b1, `DLC_IDX_POWER, 8'h0); // rate code 15 is invalid, so no link
      `CHK(power_mode_o, DLC_PM_RESET)
      bus(1'b1, `DLC_IDX_RATE, 8'h1);
      bus(1'b1, `DLC_IDX_POWER, 8'h0);
      bus(1'b0, `DLC_IDX_LINKST, 8'h0);
      `CHK({power_mode_o, link_active_o, q[6]}, {DLC_PM_NORMAL, 2'h3})
      bus(1'b0, `DLC_IDX_LINE_SIDE_REVISION, 8'h0);
      `CHK(q, 8'h14)
      bus(1'b1, `DLC_IDX_GAIN, 8'h00);
      s = rx_line_i;
      @(posedge clk_i);
      `CHK(rx_data_o, s)
      bus(1'b1, `DLC_IDX_HOOK, 8'h1);
      repeat (40) begin
         @(posedge clk_i);
         if (cal_busy_o === 1'b1) n++;
      end
      `CHK(n, 20)
      bus(1'b1, `DLC_IDX_TEST, 8'h02); // one test mode at a time
      `CHK({barrier_loopback_o, line_analog_loopback_o, hybrid_enable_o}, 3'h5)
      bus(1'b1, `DLC_IDX_TEST, 8'h00);
      bus(1'b1, `DLC_IDX_LOOP, 8'h0a);
      `CHK({barrier_loopback_o, line_analog_loopback_o, hybrid_enable_o}, 3'h3)
      bus(1'b1, `DLC_IDX_LOOP, 8'h00);
      `CHK({barrier_loopback_o, line_analog_loopback_o, hybrid_enable_o}, 3'h0)
      load_ma <= 8'h64;
      bus(1'b1, `DLC_IDX_LEGTERM, 8'h3);
      bus(1'b1, `DLC_IDX_CAL, 8'h08);
      bus(1'b0, `DLC_IDX_OVLST, 8'h0);
      `CHK({term_o, term_800_o, q[0]}, 7'h47)
      bus(1'b1, `DLC_IDX_LEGTERM, 8'h1);
      `CHK({term_o, term_800_o}, 6'h1c)
      load_ma <= 8'ha1;
      bus(1'b1, `DLC_IDX_LEGTERM, 8'h2);
      `CHK({term_o, term_800_o}, 6'h21)
      bus(1'b1, `DLC_IDX_OVLST, 8'h00); // clear while overload is live: set wins
      bus(1'b0, `DLC_IDX_OVLST, 8'h0);
      `CHK(q[0], 1'b1)
      load_ma <= 8'h0;
      bus(1'b1, `DLC_IDX_OVLST, 8'h00);
      bus(1'b0, `DLC_IDX_OVLST, 8'h0);
      `CHK(q[0], 1'b0)
      line_power_ok_i <= 1'b0; // power loss restarts calibration
      repeat (4) @(posedge clk_i);
      `CHK(cal_busy_o, 1'b1)
      line_power_ok_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      bus(1'b1, `DLC_IDX_CAL, 8'h20); // manual run: disable auto, pulse trigger
      bus(1'b1, `DLC_IDX_CAL, 8'h60);
      bus(1'b1, `DLC_IDX_CAL, 8'h20);
      repeat (18) @(posedge clk_i);
      `CHK(cal_busy_o, 1'b1)
      @(posedge clk_i);
      `CHK(cal_busy_o, 1'b0)
   endtask
   // sleep holds until reset; alternate map gives wide level and override
   task automatic t_power;
      bus(1'b1, `DLC_IDX_POWER, 8'h08);
      bus(1'b1, `DLC_IDX_POWER, 8'h00);
      `CHK(power_mode_o, DLC_PM_SLEEP)
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      `CHK(power_mode_o, DLC_PM_RESET)
      bus(1'b1, `DLC_IDX_TEST, 8'h40);
      bus(1'b1, `DLC_IDX_TXLVL, 8'ha5);
      bus(1'b1, `DLC_IDX_TERM, 8'h40);
      `CHK({tx_level_o, term_800_o}, 9'h14b)
      bus(1'b1, `DLC_IDX_POWER, 8'h18);
      `CHK(power_mode_o, DLC_PM_FULL)
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      t_reset();
      t_paths();
      t_line();
      t_power();
      close_out();
   end
endmodule
